// File: inc/oap_pkg.sv
// constants, states and carrier types of the self-programming sequencer
package oap_pkg;
  // --------------------------------------------------------------
  // mode codes and memory map
  // --------------------------------------------------------------
  localparam logic [3:0] MODE_CODE_AUTO = 4'hC;
  localparam logic [3:0] MODE_CODE_DUMP = 4'h6;
  localparam logic [15:0] EXT_WIDTH = 16'h4014;
  localparam logic [15:0] EXT_KEY = 16'h4020;
  localparam logic [15:0] INT_BASE = 16'h2000;
  localparam logic [15:0] INT_KEY = 16'h2020;
  localparam logic [15:0] INT_CFG_ZERO = 16'h2018;
  localparam logic [15:0] MAP_OFFSET = 16'h2000;
  localparam logic [1:0] BUS_WINDOW = 2'h1;
  localparam logic [15:0] BANK_SPLIT = 16'h8000;
  localparam logic [15:0] BANK_LOW_OFFSET = 16'h8000;
  localparam logic [15:0] DUMP_LOW_BASE = 16'h2000;
  localparam logic [15:0] DUMP_HIGH_BASE = 16'h5000;
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;
  localparam logic [2:0] KEY_LAST = 3'h7;
  localparam int LOCK_BIT_LO = 6;
  localparam int LOCK_BIT_HI = 7;
  // programming configuration loaded into the chip config registers
  localparam logic [15:0] PROG_CFG_VALUE = 16'hFFFF;
  // --------------------------------------------------------------
  // timing and register file
  // --------------------------------------------------------------
  localparam int WIDTH_TICK_CYCLES = 1;
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_FAILS = 12'h008;
  localparam logic [11:0] REG_CTRL = 12'h00C;
  localparam logic [11:0] REG_WIDTH = 12'h010;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [1:0] MD_NONE = 2'h0;
  localparam logic [1:0] MD_AUTO = 2'h1;
  localparam logic [1:0] MD_DUMP = 2'h2;

  typedef enum logic [3:0] {
    ST_BOOT = 4'h0, ST_CCB_RD = 4'h1, ST_KEY_RD = 4'h2, ST_KEY_CMP = 4'h3,
    ST_WIDTH_RD = 4'h4, ST_SCAN_RD = 4'h5, ST_PULSE = 4'h6, ST_VERIFY = 4'h7,
    ST_NEXT = 4'h8, ST_DUMP_RD = 4'h9, ST_DUMP_WR = 4'hA, ST_DONE = 4'hB,
    ST_HANG = 4'hC, ST_IDLE = 4'hD
  } oap_state_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } oap_ext_req_type;

  typedef struct packed {
    logic busy;
    logic hi;
    logic done;
    oap_ext_req_type req;
    logic [15:0] word;
  } oap_port_st_type;

  typedef struct packed {
    logic active;
    logic done;
    logic [15:0] div;
    logic [15:0] cnt;
  } oap_timer_st_type;
endpackage

// File: rtl/oap_ext_port.sv
// external memory port: one word per request, split into bytes on an 8-bit bus
`timescale 1ns/100ps
module oap_ext_port #(
  parameter bit BYTE_BUS = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request side
  input wire logic start,
  input oap_pkg::oap_ext_req_type req,
  output logic done,
  output logic [15:0] rdata,
  // memory bus
  input wire logic ext_ack,
  input wire logic [15:0] ext_rdata,
  output logic ext_req,
  output logic ext_we,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata
);
  oap_pkg::oap_port_st_type s_r;
  oap_pkg::oap_port_st_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy) begin
      if (start) begin
        s_nxt.busy = 1'b1;
        s_nxt.hi = 1'b0;
        s_nxt.req = req;
      end
    end else if (ext_ack) begin
      if (BYTE_BUS && !s_r.hi) begin
        // low byte first, high byte at the next address
        s_nxt.word[7:0] = ext_rdata[7:0];
        s_nxt.hi = 1'b1;
        s_nxt.req.addr = s_r.req.addr + 16'h0001;
        s_nxt.req.wdata = {8'h00, s_r.req.wdata[15:8]};
      end else begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.word = BYTE_BUS ? {ext_rdata[7:0], s_r.word[7:0]} : ext_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;
  assign rdata = s_r.word;
  assign ext_req = s_r.busy;
  assign ext_we = s_r.req.we;
  assign ext_addr = s_r.req.addr;
  assign ext_wdata = s_r.req.wdata;
endmodule

// File: rtl/oap_pulse_timer.sv
// programming pulse of a loaded width, counted in divider ticks
`timescale 1ns/100ps
module oap_pulse_timer #(
  parameter int TICK_CYCLES = oap_pkg::WIDTH_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic [15:0] width,
  output logic prog,
  output logic done
);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  oap_pkg::oap_timer_st_type s_r;
  oap_pkg::oap_timer_st_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start && !s_r.active) begin
      s_nxt.active = 1'b1;
      s_nxt.div = 16'h0000;
      // a zero width still gives one tick
      s_nxt.cnt = (width == 16'h0000) ? 16'h0001 : width;
    end else if (s_r.active) begin
      if (s_r.div == TICK_LAST) begin
        s_nxt.div = 16'h0000;
        if (s_r.cnt == 16'h0001) begin
          s_nxt.active = 1'b0;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end else begin
        s_nxt.div = s_r.div + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prog = s_r.active;
  assign done = s_r.done;
endmodule

// File: rtl/oap_sequencer.sv
// self-programming and dump sequencer with its register slave
`timescale 1ns/100ps
module oap_sequencer #(
  parameter bit BANKED = 1'b0,
  parameter bit HAS_BW_PIN = 1'b1,
  parameter logic [15:0] OTP_LAST = 16'h4FFE,
  parameter logic [7:0] PULSES = 8'h19
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps and fuses
  input wire logic [3:0] mode_select_inputs,
  input wire logic external_fetch_disable_fuse,
  // external memory bus
  input wire logic ext_ack,
  input wire logic [15:0] ext_rdata,
  output logic ext_req,
  output logic ext_we,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  output logic bank_select_high,
  output logic bank_select_low,
  output logic bus_width_8,
  // internal array
  input wire logic [15:0] otp_rdata,
  output logic [15:0] otp_addr,
  output logic [15:0] otp_wdata,
  output logic otp_prog,
  // status
  output logic programming_active_n,
  output logic verify_ok_flag,
  output logic [15:0] chip_config_registers
);
  typedef struct packed {
    oap_pkg::oap_state_type state;
    logic [1:0] mode;
    logic sub;
    logic [15:0] int_addr;
    logic [2:0] key_idx;
    logic [7:0] pulse_cnt;
    logic [15:0] pulse_width_value;
    logic [15:0] word;
    logic [15:0] fails;
    logic act_n;
    logic ver_ok;
    logic ext_start;
    oap_pkg::oap_ext_req_type req;
    logic [1:0] bank;
    logic pulse_start;
    logic [15:0] otp_addr;
    logic [15:0] otp_wdata;
    logic [15:0] cfg_regs;
    logic hold;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic bw8;
  } oap_seq_st_type;

  oap_seq_st_type s_r;
  oap_seq_st_type s_nxt;
  logic ext_done;
  logic [15:0] ext_word;
  logic pulse_done;

  // --------------------------------------------------------------
  // address maps
  // --------------------------------------------------------------
  function automatic logic [17:0] map_auto(input logic [15:0] a);
    logic [15:0] circ;
    circ = a + oap_pkg::MAP_OFFSET;
    if (BANKED) begin
      if (a < oap_pkg::BANK_SPLIT) begin
        map_auto = {2'b00, a + oap_pkg::BANK_LOW_OFFSET};
      end else begin
        map_auto = {2'b01, a};
      end
    end else begin
      map_auto = {circ[15:14], oap_pkg::BUS_WINDOW, circ[13:0]};
    end
  endfunction

  function automatic logic [17:0] map_dump(input logic [15:0] a);
    logic [15:0] off;
    off = 16'h0000;
    if (BANKED) begin
      if (a < oap_pkg::BANK_SPLIT) begin
        off = a - oap_pkg::INT_BASE;
        map_dump = {2'b00, oap_pkg::DUMP_LOW_BASE + {1'b0, off[15:1]}};
      end else begin
        off = a - oap_pkg::BANK_SPLIT;
        map_dump = {2'b00, oap_pkg::DUMP_HIGH_BASE + {1'b0, off[15:1]}};
      end
    end else begin
      map_dump = map_auto(a);
    end
  endfunction

  function automatic logic [31:0] reg_read(input oap_seq_st_type s, input logic [11:0] a);
    case (a)
      oap_pkg::REG_STATUS: reg_read = {20'h00000, s.bw8, s.ver_ok, s.act_n, 1'b0, s.mode,
                                       s.sub, 1'b0, s.state};
      oap_pkg::REG_ADDR: reg_read = {16'h0000, s.int_addr};
      oap_pkg::REG_FAILS: reg_read = {16'h0000, s.fails};
      oap_pkg::REG_CTRL: reg_read = {31'h00000000, s.hold};
      oap_pkg::REG_WIDTH: reg_read = {16'h0000, s.pulse_width_value};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == oap_pkg::REG_STATUS) || (a == oap_pkg::REG_ADDR) ||
             (a == oap_pkg::REG_FAILS) || (a == oap_pkg::REG_CTRL) || (a == oap_pkg::REG_WIDTH);
  endfunction

  // --------------------------------------------------------------
  // sequencer and register slave
  // --------------------------------------------------------------
  always_comb begin
    logic [17:0] m;
    m = 18'h00000;
    s_nxt = s_r;
    s_nxt.ext_start = 1'b0;
    s_nxt.pulse_start = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = reg_read(s_r, paddr);
      s_nxt.pslverr = !mapped(paddr);
    end
    if (psel && penable && s_r.pready && pwrite && paddr == oap_pkg::REG_CTRL) begin
      s_nxt.hold = pwdata[0];
    end
    // hold only pauses between steps, never inside a transfer
    if (!(s_r.hold && !s_r.sub)) begin
      case (s_r.state)
        oap_pkg::ST_BOOT: begin
          s_nxt.act_n = 1'b1;
          s_nxt.bw8 = HAS_BW_PIN;
          if (mode_select_inputs == oap_pkg::MODE_CODE_AUTO) begin
            s_nxt.mode = oap_pkg::MD_AUTO;
            s_nxt.cfg_regs = oap_pkg::PROG_CFG_VALUE;
            s_nxt.otp_addr = oap_pkg::INT_CFG_ZERO;
            s_nxt.state = oap_pkg::ST_CCB_RD;
          end else if (mode_select_inputs == oap_pkg::MODE_CODE_DUMP) begin
            s_nxt.mode = oap_pkg::MD_DUMP;
            s_nxt.cfg_regs = oap_pkg::PROG_CFG_VALUE;
            if (external_fetch_disable_fuse) begin
              s_nxt.state = oap_pkg::ST_IDLE;
            end else begin
              s_nxt.state = oap_pkg::ST_KEY_RD;
            end
          end else begin
            s_nxt.state = oap_pkg::ST_IDLE;
          end
        end
        oap_pkg::ST_CCB_RD: begin
          if (!s_r.sub) begin
            s_nxt.sub = 1'b1;
          end else begin
            s_nxt.sub = 1'b0;
            // a programmed lock bit reads as zero
            if (!otp_rdata[oap_pkg::LOCK_BIT_LO] || !otp_rdata[oap_pkg::LOCK_BIT_HI]) begin
              s_nxt.state = oap_pkg::ST_KEY_RD;
            end else begin
              s_nxt.state = oap_pkg::ST_WIDTH_RD;
            end
          end
        end
        oap_pkg::ST_KEY_RD: begin
          if (!s_r.sub) begin
            s_nxt.sub = 1'b1;
            s_nxt.ext_start = 1'b1;
            s_nxt.bank = 2'b00;
            s_nxt.req = '{we: 1'b0, addr: oap_pkg::EXT_KEY + {12'h000, s_r.key_idx, 1'b0},
                          wdata: 16'h0000};
          end else if (ext_done) begin
            s_nxt.sub = 1'b0;
            s_nxt.word = ext_word;
            s_nxt.otp_addr = oap_pkg::INT_KEY + {12'h000, s_r.key_idx, 1'b0};
            s_nxt.state = oap_pkg::ST_KEY_CMP;
          end
        end
        oap_pkg::ST_KEY_CMP: begin
          if (!s_r.sub) begin
            s_nxt.sub = 1'b1;
          end else begin
            s_nxt.sub = 1'b0;
            if (otp_rdata != s_r.word) begin
              s_nxt.state = oap_pkg::ST_HANG;
            end else if (s_r.key_idx == oap_pkg::KEY_LAST) begin
              s_nxt.key_idx = 3'h0;
              s_nxt.state = oap_pkg::ST_WIDTH_RD;
            end else begin
              s_nxt.key_idx = s_r.key_idx + 3'h1;
              s_nxt.state = oap_pkg::ST_KEY_RD;
            end
          end
        end
        oap_pkg::ST_WIDTH_RD: begin
          if (!s_r.sub) begin
            s_nxt.sub = 1'b1;
            s_nxt.ext_start = 1'b1;
            s_nxt.bank = 2'b00;
            s_nxt.req = '{we: 1'b0, addr: oap_pkg::EXT_WIDTH, wdata: 16'h0000};
          end else if (ext_done) begin
            s_nxt.sub = 1'b0;
            s_nxt.pulse_width_value = ext_word;
            s_nxt.act_n = 1'b0;
            s_nxt.int_addr = oap_pkg::INT_BASE;
            s_nxt.otp_addr = oap_pkg::INT_BASE;
            if (s_r.mode == oap_pkg::MD_AUTO) begin
              s_nxt.ver_ok = 1'b1;
              s_nxt.state = oap_pkg::ST_SCAN_RD;
            end else begin
              s_nxt.state = oap_pkg::ST_DUMP_RD;
            end
          end
        end
        oap_pkg::ST_SCAN_RD: begin
          if (!s_r.sub) begin
            m = map_auto(s_r.int_addr);
            s_nxt.sub = 1'b1;
            s_nxt.ext_start = 1'b1;
            s_nxt.bank = m[17:16];
            s_nxt.req = '{we: 1'b0, addr: m[15:0], wdata: 16'h0000};
          end else if (ext_done) begin
            s_nxt.sub = 1'b0;
            s_nxt.word = ext_word;
            if (ext_word == oap_pkg::BLANK_WORD) begin
              s_nxt.state = oap_pkg::ST_NEXT;
            end else begin
              s_nxt.otp_addr = s_r.int_addr;
              s_nxt.otp_wdata = ext_word;
              s_nxt.pulse_cnt = 8'h00;
              s_nxt.state = oap_pkg::ST_PULSE;
            end
          end
        end
        oap_pkg::ST_PULSE: begin
          if (!s_r.sub) begin
            s_nxt.sub = 1'b1;
            s_nxt.pulse_start = 1'b1;
          end else if (pulse_done) begin
            s_nxt.sub = 1'b0;
            if (s_r.pulse_cnt == PULSES - 8'h01) begin
              s_nxt.state = oap_pkg::ST_VERIFY;
            end else begin
              s_nxt.pulse_cnt = s_r.pulse_cnt + 8'h01;
            end
          end
        end
        oap_pkg::ST_VERIFY: begin
          if (!s_r.sub) begin
            s_nxt.sub = 1'b1;
          end else begin
            s_nxt.sub = 1'b0;
            if (otp_rdata != s_r.word) begin
              s_nxt.ver_ok = 1'b0;
              s_nxt.fails = s_r.fails + 16'h0001;
            end
            s_nxt.state = oap_pkg::ST_NEXT;
          end
        end
        oap_pkg::ST_NEXT: begin
          if (s_r.int_addr == OTP_LAST) begin
            s_nxt.act_n = 1'b1;
            s_nxt.state = oap_pkg::ST_DONE;
          end else begin
            s_nxt.int_addr = s_r.int_addr + 16'h0002;
            s_nxt.otp_addr = s_r.int_addr + 16'h0002;
            s_nxt.state = (s_r.mode == oap_pkg::MD_AUTO) ? oap_pkg::ST_SCAN_RD :
                                                            oap_pkg::ST_DUMP_RD;
          end
        end
        oap_pkg::ST_DUMP_RD: begin
          if (!s_r.sub) begin
            s_nxt.sub = 1'b1;
          end else begin
            s_nxt.sub = 1'b0;
            s_nxt.word = otp_rdata;
            s_nxt.state = oap_pkg::ST_DUMP_WR;
          end
        end
        oap_pkg::ST_DUMP_WR: begin
          if (!s_r.sub) begin
            m = map_dump(s_r.int_addr);
            s_nxt.sub = 1'b1;
            s_nxt.ext_start = 1'b1;
            s_nxt.bank = m[17:16];
            s_nxt.req = '{we: 1'b1, addr: m[15:0], wdata: s_r.word};
          end else if (ext_done) begin
            s_nxt.sub = 1'b0;
            s_nxt.state = oap_pkg::ST_NEXT;
          end
        end
        oap_pkg::ST_DONE, oap_pkg::ST_HANG, oap_pkg::ST_IDLE: begin
          s_nxt.state = s_r.state;
        end
        default: begin
          s_nxt.state = oap_pkg::ST_HANG;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.state <= oap_pkg::ST_BOOT;
      s_r.act_n <= 1'b0;
      s_r.hold <= oap_pkg::CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------
  // bus port and pulse timer
  // --------------------------------------------------------------
  oap_ext_port #(.BYTE_BUS(HAS_BW_PIN)) u_port (
    .pclk(pclk),
    .presetn(presetn),
    .start(s_r.ext_start),
    .req(s_r.req),
    .done(ext_done),
    .rdata(ext_word),
    .ext_ack(ext_ack),
    .ext_rdata(ext_rdata),
    .ext_req(ext_req),
    .ext_we(ext_we),
    .ext_addr(ext_addr),
    .ext_wdata(ext_wdata)
  );

  oap_pulse_timer #(.TICK_CYCLES(oap_pkg::WIDTH_TICK_CYCLES)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(s_r.pulse_start),
    .width(s_r.pulse_width_value),
    .prog(otp_prog),
    .done(pulse_done)
  );

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign bank_select_high = s_r.bank[1];
  assign bank_select_low = s_r.bank[0];
  assign bus_width_8 = s_r.bw8;
  assign otp_addr = s_r.otp_addr;
  assign otp_wdata = s_r.otp_wdata;
  assign programming_active_n = s_r.act_n;
  assign verify_ok_flag = s_r.ver_ok;
  assign chip_config_registers = s_r.cfg_regs;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hang_frozen_a: assert property (s_r.state == oap_pkg::ST_HANG |=>
    $stable(programming_active_n) && $stable(verify_ok_flag) && !ext_req)
    else $error("status moved or bus active while hung");
  done_release_a: assert property (s_r.state == oap_pkg::ST_DONE |-> programming_active_n)
    else $error("active still low after finish");
  blank_skip_a: assert property (s_r.state == oap_pkg::ST_SCAN_RD && s_r.sub && ext_done &&
    ext_word == oap_pkg::BLANK_WORD && !s_r.hold |=> s_r.state == oap_pkg::ST_NEXT)
    else $error("blank word not skipped");
  key_mismatch_a: assert property (s_r.state == oap_pkg::ST_KEY_CMP && s_r.sub &&
    otp_rdata != s_r.word |=> s_r.state == oap_pkg::ST_HANG)
    else $error("key mismatch did not hang");
  verify_drop_a: assert property (s_r.state == oap_pkg::ST_VERIFY && s_r.sub &&
    otp_rdata != s_r.word |=> !verify_ok_flag)
    else $error("verify flag kept after failure");
  fuse_refuse_a: assert property (s_r.state == oap_pkg::ST_BOOT && !s_r.hold &&
    mode_select_inputs == oap_pkg::MODE_CODE_DUMP && external_fetch_disable_fuse
    |=> s_r.state == oap_pkg::ST_IDLE [*3])
    else $error("dump started despite fuse");
  dump_active_a: assert property ((s_r.state == oap_pkg::ST_DUMP_RD ||
    s_r.state == oap_pkg::ST_DUMP_WR) |-> !programming_active_n)
    else $error("active high during dump");
  scan_start_a: assert property (s_r.state == oap_pkg::ST_WIDTH_RD && s_r.sub && ext_done &&
    s_r.mode == oap_pkg::MD_AUTO |=> s_r.int_addr == oap_pkg::INT_BASE &&
    !programming_active_n && verify_ok_flag && s_r.pulse_width_value == $past(ext_word))
    else $error("programming did not start at base");
  pulse_count_a: assert property ($rose(s_r.state == oap_pkg::ST_VERIFY) |->
    s_r.pulse_cnt == PULSES - 8'h01)
    else $error("verify before all pulses");
  bus_width_a: assert property (s_r.state != oap_pkg::ST_BOOT |-> bus_width_8 == HAS_BW_PIN)
    else $error("bus width wrong for variant");
endmodule

// File: test/oap_ext_mem.sv
// external byte-wide memory answering the sequencer's bus
`timescale 1ns/100ps
module oap_ext_mem (
  // clock and answer delay
  input wire logic pclk,
  input wire logic [3:0] lat,
  // memory bus
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  input wire logic bank_select_high,
  input wire logic bank_select_low,
  output logic ext_ack,
  output logic [15:0] ext_rdata
);
  logic [7:0] mem [0:65535];
  logic [3:0] cnt;
  logic [15:0] idx;
  assign idx = {bank_select_high, bank_select_low, ext_addr[13:0]};
  initial begin
    ext_ack = 1'b0;
    ext_rdata = 16'h0000;
    cnt = 4'h0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
  end
  always @(posedge pclk) begin
    if (ext_ack || !ext_req) begin
      ext_ack <= 1'b0;
      cnt <= 4'h0;
      // released data lines keep changing
      ext_rdata <= ~ext_rdata;
    end else if (cnt >= lat) begin
      ext_ack <= 1'b1;
      ext_rdata <= {~mem[idx], mem[idx]};
      if (ext_we) mem[idx] <= ext_wdata[7:0];
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// File: test/tb.sv
// self-checking bench for the self-programming sequencer
`timescale 1ns/100ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ext_ack, ext_req, ext_we;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] mode_select_inputs, lat;
  logic external_fetch_disable_fuse, bank_select_high, bank_select_low, bus_width_8, otp_prog;
  logic programming_active_n, verify_ok_flag;
  logic [15:0] ext_rdata, ext_addr, ext_wdata, otp_rdata, otp_addr, otp_wdata, bad;
  logic [15:0] chip_config_registers;
  logic [15:0] otp [0:32767];
  int err_total, n_tests;
  oap_sequencer #(.OTP_LAST(16'h2006), .PULSES(8'h02)) dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .mode_select_inputs,
    .external_fetch_disable_fuse, .ext_ack, .ext_rdata, .ext_req, .ext_we, .ext_addr, .ext_wdata,
    .bank_select_high, .bank_select_low, .bus_width_8, .otp_rdata, .otp_addr, .otp_wdata,
    .otp_prog, .programming_active_n, .verify_ok_flag, .chip_config_registers);
  oap_ext_mem mem_i (.pclk, .lat, .ext_req, .ext_we, .ext_addr, .ext_wdata, .bank_select_high,
    .bank_select_low, .ext_ack, .ext_rdata);
  // internal array; one cell can be made to refuse programming
  always @(posedge pclk) begin
    if (otp_prog && otp_addr !== bad) otp[otp_addr[15:1]] <= otp_wdata;
    otp_rdata <= otp[otp_addr[15:1]];
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task complete_run;
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task run(input logic [3:0] m, input logic f);
    presetn <= 1'b0;
    mode_select_inputs <= m;
    external_fetch_disable_fuse <= f;
    repeat (16) @(posedge pclk);
    chk("programming_active_n_in_reset", programming_active_n, 1'b0);
    presetn <= 1'b1;
    // active output must leave its reset level before any width is loaded
    repeat (2) @(posedge pclk);
    chk("programming_active_n_boot", programming_active_n, 1'b1);
  endtask
  task wait_active(input logic v);
    for (int i = 0; i < 4000 && programming_active_n !== v; i++) @(posedge pclk);
    chk("programming_active_n", programming_active_n, v);
  endtask
  task t_auto;
    mem_i.mem[16'h0014] = 8'h03;
    mem_i.mem[16'h0015] = 8'h00;
    mem_i.mem[16'h4000] = 8'h34;
    mem_i.mem[16'h4001] = 8'h12;
    mem_i.mem[16'h4004] = 8'hCD;
    mem_i.mem[16'h4005] = 8'hAB;
    mem_i.mem[16'h4006] = 8'h5A;
    mem_i.mem[16'h4007] = 8'h5A;
    mem_i.mem[16'h4019] = 8'h20;
    bad = 16'h2004;
    run(4'hC, 1'b0);
    wait_active(1'b0);
    chk("ver_start", verify_ok_flag, 1'b1);
    chk("ccr", chip_config_registers, oap_pkg::PROG_CFG_VALUE);
    wait_active(1'b1);
    chk("ver_fail", verify_ok_flag, 1'b0);
    chk("word0", otp[16'h1000], 16'h1234);
    chk("blank", otp[16'h1001], 16'h0000);
    chk("word3", otp[16'h1003], 16'h5A5A);
    chk("bw8", bus_width_8, 1'b1);
    apb(1'b0, oap_pkg::REG_WIDTH, 32'h0000_0000);
    chk("ppw", rd, 32'h0000_0003);
    apb(1'b0, oap_pkg::REG_FAILS, 32'h0000_0000);
    chk("fails", rd, 32'h0000_0001);
    apb(1'b0, oap_pkg::REG_STATUS, 32'h0000_0000);
    chk("status", rd, 32'h0000_0A4B);
    apb(1'b0, 12'hFF0, 32'h0000_0000);
    chk("unmapped", er, 1'b1);
    apb(1'b1, oap_pkg::REG_CTRL, 32'h0000_0001);
    apb(1'b0, oap_pkg::REG_CTRL, 32'h0000_0000);
    chk("hold", rd, 32'h0000_0001);
    chk("bus_quiet", ext_req, 1'b0);
  endtask
  task t_dump;
    for (int i = 0; i < 8; i++) mem_i.mem[16'h4000 + i] = 8'h00;
    bad = 16'h0000;
    lat <= 4'h3;
    run(4'h6, 1'b0);
    wait_active(1'b0);
    wait_active(1'b1);
    chk("dump_lo", mem_i.mem[16'h4000], 8'h34);
    chk("dump_hi", mem_i.mem[16'h4007], 8'h5A);
  endtask
  task t_refuse;
    mem_i.mem[16'h4000] = 8'h00;
    run(4'h6, 1'b1);
    repeat (400) @(posedge pclk);
    chk("fuse_programming_active_n", programming_active_n, 1'b1);
    chk("fuse_mem", mem_i.mem[16'h4000], 8'h00);
    mem_i.mem[16'h0020] = 8'h00;
    run(4'h6, 1'b0);
    repeat (400) @(posedge pclk);
    chk("key_programming_active_n", programming_active_n, 1'b1);
    chk("key_mem", mem_i.mem[16'h4000], 8'h00);
    otp[16'h100C] = 16'hFF7F;
    mem_i.mem[16'h4000] = 8'h0F;
    run(4'hC, 1'b0);
    repeat (400) @(posedge pclk);
    chk("lock_programming_active_n", programming_active_n, 1'b1);
    chk("lock_otp", otp[16'h1000], 16'h1234);
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, external_fetch_disable_fuse} = 5'h00;
    {paddr, pwdata, mode_select_inputs, lat, bad} = 68'h0;
    err_total = 0;
    n_tests = 0;
    for (int i = 0; i < 32768; i++) otp[i] = 16'hFFFF;
    otp[16'h1001] = 16'h0000;
    // let the memory model fill itself before the image is written
    @(posedge pclk);
    t_auto;
    t_dump;
    t_refuse;
    complete_run;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    complete_run;
  end
endmodule
